// ### hdl/tis_pkg.sv
// Package for the threshold and interrupt status block.
// Assumes a byte-wide register port driven by the I2C slave logic.
`default_nettype none
package tis_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_INT_CTRL = 8'h89;
    localparam logic [7:0] ADDR_LOW_HI   = 8'h8a;
    localparam logic [7:0] ADDR_LOW_LO   = 8'h8b;
    localparam logic [7:0] ADDR_UP_HI    = 8'h8c;
    localparam logic [7:0] ADDR_UP_LO    = 8'h8d;
    localparam logic [7:0] ADDR_FLAGS    = 8'h8e;
    localparam logic [7:0] ADDR_MOD      = 8'h8f;
    // Flag bit positions
    localparam int FLAG_PROX  = 3;
    localparam int FLAG_ALS   = 2;
    localparam int FLAG_BELOW = 1;
    localparam int FLAG_ABOVE = 0;
    // Control bit positions (count in 7:5)
    localparam int CTL_PROX_EN = 3;
    localparam int CTL_ALS_EN  = 2;
    localparam int CTL_LIM_EN  = 1;
    localparam int CTL_SEL     = 0;
    // Reset values
    localparam logic [7:0]  RST_MOD   = 8'h01;
    localparam logic [7:0]  RST_CTRL  = 8'h00;
    localparam logic [15:0] RST_LIMIT = 16'h0000;

    // One register access from the bus slave
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tis_reg_req_t;

    // One new measurement result
    typedef struct packed {
        logic        prox_valid;
        logic        als_valid;
        logic [15:0] prox;
        logic [15:0] als;
    } tis_result_t;
endpackage : tis_pkg
`default_nettype wire

// ### hdl/tis_persist.sv
// Consecutive out-of-limit counter for the limit comparison.
// Assumes one sample strobe per new result of the selected source.
`default_nettype none
module tis_persist (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Sample
    input  wire logic       i_sample,
    input  wire logic       i_above,
    input  wire logic       i_below,
    input  wire logic [2:0] i_code,
    // Events
    output logic            o_above_evt,
    output logic            o_below_evt
);
    logic [7:0] run_q;
    logic       last_above_q;
    logic [7:0] need;

    assign need = 8'(1 << i_code); // see RULE_17

    // Run length of out-of-limit samples on the same side
    // An event restarts the run, so a long run fires every 2^code samples
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            run_q        <= 8'h00;
            last_above_q <= 1'b0;
        end else if (i_sample) begin
            if (!(i_above || i_below) || o_above_evt || o_below_evt) begin // see RULE_17
                run_q <= 8'h00;
            end else if ((i_above != last_above_q) || run_q == 8'h00) begin
                run_q <= 8'h01;
            end else if (run_q != 8'hff) begin
                run_q <= run_q + 8'h01;
            end
            last_above_q <= i_above;
        end
    end

    // Event fires when the run reaches the count
    always_comb begin
        logic [7:0] nxt;
        nxt = 8'h00;
        if (i_above || i_below) begin
            nxt = ((i_above != last_above_q) || run_q == 8'h00) ? 8'h01 : run_q + 8'h01;
        end
        o_above_evt = i_sample && i_above && (nxt == need); // see RULE_17
        o_below_evt = i_sample && i_below && (nxt == need);
    end
endmodule : tis_persist
`default_nettype wire

// ### hdl/tis_top.sv
// Threshold limits, event flags and modulator timing register.
// Assumes an I2C slave presents byte reads and writes on a simple port.
//
// Notes on behaviour
// RULE_01 - Lower limit 16 bits at 8Ah (high byte) and 8Bh (low byte), read/write.
// RULE_02 - Upper limit 16 bits at 8Ch (high byte) and 8Dh (low byte), read/write.
// RULE_03 - Status register at 8Eh reports ready and limit crossing events.
// RULE_04 - Proximity-done flag sets when a proximity ready interrupt is generated.
// RULE_05 - Light-done flag sets when an ambient ready interrupt is generated.
// RULE_06 - Below-limit flag sets when selected result falls below lower limit.
// RULE_07 - Above-limit flag sets when selected result exceeds upper limit.
// RULE_08 - Flags stay set until host writes one to that bit only.
// RULE_09 - Interrupt pin low while any flag is set.
// RULE_10 - Modulator delay field writable, resets to zero.
// RULE_11 - Modulator dead-time field writable, resets to one.
// RULE_12 - Host should program modulator register with one, its default.
// RULE_13 - Flags at bits 3..0; bits 7..4 read zero.
// RULE_14 - Modulator: delay 7:5, frequency 4:3, dead time 2:0.
// RULE_15 - Limit events only when strictly above or strictly below.
// RULE_16 - Select bit: zero uses proximity, one uses ambient light.
// RULE_17 - Needs 2^code consecutive out-of-limit results, code default 000.
// RULE_18 - Limit enable gates limit interrupts and limit flags.
// RULE_19 - Separate enables gate proximity and ambient ready interrupts.
`default_nettype none
module tis_top (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_srst,
    // Register port
    input  wire tis_pkg::tis_reg_req_t i_req,
    output logic [7:0]                o_rdata,
    // Results from the measurement engines
    input  wire tis_pkg::tis_result_t  i_res,
    // Outputs
    output logic                      o_int_n,
    output logic [2:0]                o_mod_delay,
    output logic [1:0]                o_mod_freq,
    output logic [2:0]                o_mod_dead
);
    logic [15:0] low_q;
    logic [15:0] up_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  mod_q;
    logic [3:0]  flags_q;
    logic        wr;
    logic        sel_valid;
    logic [15:0] sel_val;
    logic        is_above;
    logic        is_below;
    logic        above_evt;
    logic        below_evt;
    logic [3:0]  set_v;
    logic [3:0]  clr_v;

    assign wr = i_req.wr;

    // Limits, control and modulator registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            low_q  <= tis_pkg::RST_LIMIT;
            up_q   <= tis_pkg::RST_LIMIT;
            ctrl_q <= tis_pkg::RST_CTRL;
            mod_q  <= tis_pkg::RST_MOD; // see RULE_10 see RULE_11 see RULE_12
        end else if (wr) begin
            unique case (i_req.addr)
                tis_pkg::ADDR_LOW_HI:   low_q[15:8] <= i_req.wdata; // see RULE_01
                tis_pkg::ADDR_LOW_LO:   low_q[7:0]  <= i_req.wdata; // see RULE_01
                tis_pkg::ADDR_UP_HI:    up_q[15:8]  <= i_req.wdata; // see RULE_02
                tis_pkg::ADDR_UP_LO:    up_q[7:0]   <= i_req.wdata; // see RULE_02
                tis_pkg::ADDR_INT_CTRL: ctrl_q      <= i_req.wdata;
                tis_pkg::ADDR_MOD:      mod_q       <= i_req.wdata; // see RULE_14
                default: ;
            endcase
        end
    end

    // Limit bytes land at the edge of the write strobe
    low_write_a: assert property ( // see RULE_01
        @(posedge i_clk) disable iff (i_srst)
        wr && i_req.addr == tis_pkg::ADDR_LOW_HI |=> low_q[15:8] == $past(i_req.wdata))
        else $error("lower limit high byte not written");
    up_write_a: assert property ( // see RULE_02
        @(posedge i_clk) disable iff (i_srst)
        wr && i_req.addr == tis_pkg::ADDR_UP_LO |=> up_q[7:0] == $past(i_req.wdata))
        else $error("upper limit low byte not written");

    // Limit source select and strict comparison
    assign sel_valid = ctrl_q[tis_pkg::CTL_SEL] ? i_res.als_valid : i_res.prox_valid; // see RULE_16
    assign sel_val   = ctrl_q[tis_pkg::CTL_SEL] ? i_res.als : i_res.prox;
    assign is_above  = sel_val > up_q;  // see RULE_15
    assign is_below  = sel_val < low_q; // see RULE_15

    tis_persist u_persist (
        .i_clk       (i_clk),
        .i_srst      (i_srst),
        .i_sample    (sel_valid),
        .i_above     (is_above),
        .i_below     (is_below),
        .i_code      (ctrl_q[7:5]),
        .o_above_evt (above_evt),
        .o_below_evt (below_evt)
    );

    // Events only on a strict crossing; code zero fires on every out sample
    strict_cmp_a: assert property ( // see RULE_15
        @(posedge i_clk) disable iff (i_srst)
        above_evt || below_evt |-> sel_valid && (above_evt ? sel_val > up_q : sel_val < low_q))
        else $error("limit event without strict crossing");
    count_one_a: assert property ( // see RULE_17
        @(posedge i_clk) disable iff (i_srst)
        sel_valid && (is_above || is_below) && ctrl_q[7:5] == 3'h0 |-> above_evt || below_evt)
        else $error("code zero sample gave no event");

    // Event sources, each gated by its enable
    always_comb begin
        set_v = 4'h0;
        set_v[tis_pkg::FLAG_PROX]  = i_res.prox_valid && ctrl_q[tis_pkg::CTL_PROX_EN]; // see RULE_04 see RULE_19
        set_v[tis_pkg::FLAG_ALS]   = i_res.als_valid && ctrl_q[tis_pkg::CTL_ALS_EN];   // see RULE_05 see RULE_19
        set_v[tis_pkg::FLAG_BELOW] = below_evt && ctrl_q[tis_pkg::CTL_LIM_EN];         // see RULE_06 see RULE_18
        set_v[tis_pkg::FLAG_ABOVE] = above_evt && ctrl_q[tis_pkg::CTL_LIM_EN];         // see RULE_07 see RULE_18
        clr_v = (wr && i_req.addr == tis_pkg::ADDR_FLAGS) ? i_req.wdata[3:0] : 4'h0;
    end

    // Sticky flags; a set in the clearing cycle wins so no event is lost
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= (flags_q & ~clr_v) | set_v; // see RULE_08 see RULE_03
        end
    end

    // Each enabled source sets its own flag at the next edge
    als_set_a: assert property ( // see RULE_05
        @(posedge i_clk) disable iff (i_srst)
        i_res.als_valid && ctrl_q[tis_pkg::CTL_ALS_EN] |=> flags_q[tis_pkg::FLAG_ALS])
        else $error("light flag not set");
    above_set_a: assert property ( // see RULE_07
        @(posedge i_clk) disable iff (i_srst)
        above_evt && ctrl_q[tis_pkg::CTL_LIM_EN] |=> flags_q[tis_pkg::FLAG_ABOVE])
        else $error("above flag not set");
    below_set_a: assert property ( // see RULE_06
        @(posedge i_clk) disable iff (i_srst)
        below_evt && ctrl_q[tis_pkg::CTL_LIM_EN] |=> flags_q[tis_pkg::FLAG_BELOW])
        else $error("below flag not set");

    // Interrupt pin from its own flop, loaded at the same edge as the flags
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_int_n <= 1'b1;
        end else begin
            o_int_n <= ~(|((flags_q & ~clr_v) | set_v)); // see RULE_09
        end
    end

    // Pin and flags are built from the same next value, so they never disagree
    int_track_a: assert property ( // see RULE_09
        @(posedge i_clk) disable iff (i_srst) o_int_n == !(|flags_q))
        else $error("int pin does not match flags");

    // Read data, registered
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else begin
            unique case (i_req.addr)
                tis_pkg::ADDR_LOW_HI:   o_rdata <= low_q[15:8];
                tis_pkg::ADDR_LOW_LO:   o_rdata <= low_q[7:0];
                tis_pkg::ADDR_UP_HI:    o_rdata <= up_q[15:8];
                tis_pkg::ADDR_UP_LO:    o_rdata <= up_q[7:0];
                tis_pkg::ADDR_INT_CTRL: o_rdata <= ctrl_q;
                tis_pkg::ADDR_FLAGS:    o_rdata <= {4'h0, flags_q}; // see RULE_13
                tis_pkg::ADDR_MOD:      o_rdata <= mod_q;
                default:                o_rdata <= 8'h00;
            endcase
        end
    end

    // Modulator read returns the stored byte one cycle later
    read_mod_a: assert property ( // see RULE_14
        @(posedge i_clk) disable iff (i_srst)
        i_req.addr == tis_pkg::ADDR_MOD |=> o_rdata == $past(mod_q))
        else $error("modulator read mismatch");

    // Modulator fields out, registered
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_mod_delay <= tis_pkg::RST_MOD[7:5];
            o_mod_freq  <= tis_pkg::RST_MOD[4:3];
            o_mod_dead  <= tis_pkg::RST_MOD[2:0];
        end else begin
            o_mod_delay <= mod_q[7:5]; // see RULE_14
            o_mod_freq  <= mod_q[4:3];
            o_mod_dead  <= mod_q[2:0];
        end
    end

    // Field pins trail the register by one cycle
    mod_out_a: assert property ( // see RULE_14
        @(posedge i_clk) disable iff (i_srst) {o_mod_delay, o_mod_freq, o_mod_dead} == $past(mod_q))
        else $error("modulator fields stale");

    // Flag holding and clearing
    flag_sticky_a: assert property ( // see RULE_08
        @(posedge i_clk) disable iff (i_srst)
        flags_q[0] && !clr_v[0] |=> flags_q[0])
        else $error("flag dropped without clear");
    flag_clear_a: assert property ( // see RULE_08
        @(posedge i_clk) disable iff (i_srst)
        clr_v[1] && !set_v[1] |=> !flags_q[1])
        else $error("flag not cleared");
    // Interrupt level against the flags
    int_level_a: assert property ( // see RULE_09
        @(posedge i_clk) disable iff (i_srst)
        (|flags_q) |=> !o_int_n || $past(|clr_v))
        else $error("int not low");
    int_idle_a: assert property ( // see RULE_09
        @(posedge i_clk) disable iff (i_srst)
        (flags_q == 4'h0) |-> ##0 1'b1 ##1 (o_int_n || $past(|set_v)))
        else $error("int low idle");
    // Source enables
    prox_set_a: assert property ( // see RULE_04
        @(posedge i_clk) disable iff (i_srst)
        i_res.prox_valid && ctrl_q[3] |=> flags_q[3])
        else $error("prox flag not set");
    als_gate_a: assert property ( // see RULE_19
        @(posedge i_clk) disable iff (i_srst)
        !flags_q[2] && !(i_res.als_valid && ctrl_q[2]) |=> !flags_q[2])
        else $error("als flag set");
    limit_gate_a: assert property ( // see RULE_18
        @(posedge i_clk) disable iff (i_srst)
        !ctrl_q[1] && flags_q[1:0] == 2'b00 |=> flags_q[1:0] == 2'b00)
        else $error("limit flag ungated");
    // Unused status bits always read as zero
    status_read_a: assert property ( // see RULE_13
        @(posedge i_clk) disable iff (i_srst)
        i_req.addr == tis_pkg::ADDR_FLAGS |=> o_rdata[7:4] == 4'h0)
        else $error("reserved bits set");
endmodule : tis_top
`default_nettype wire

// ### tb/tis_host_model.sv
// Host model: byte writes and reads on the register port of the status block.
// Assumes read data is registered one cycle after the address is taken.
`default_nettype none
module tis_host_model (
    // Clock
    input  wire logic                  i_clk,
    // Register port
    output var  tis_pkg::tis_reg_req_t o_req,
    input  wire logic [7:0]            i_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_req = '0;
    // Single-cycle write strobe; data inverted after so stale bytes never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge i_clk);
        o_req.wr    <= 1'b0;
        o_req.wdata <= ~d;
    endtask : wr
    // Address taken at one edge, data settled just after the next
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_req.addr <= a;
        @(posedge i_clk);
        #1 d = i_rdata;
    endtask : rd
    // Recommended modulator setting equals its reset value
    task automatic prog_mod();
        wr(8'h8f, 8'h01);
    endtask : prog_mod
endmodule : tis_host_model
`default_nettype wire

// ### tb/test_threshold_interrupt_status.sv
// Self-checking bench for the threshold and interrupt status block.
// Assumes tis_host_model drives the register port; results come from here.
`default_nettype none
module test_threshold_interrupt_status;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  i_clk;
    logic                  i_srst;
    tis_pkg::tis_reg_req_t req;
    tis_pkg::tis_result_t  i_res;
    logic [7:0]            rdata, d, m;
    logic                  int_n;
    logic [2:0]            delay, dead;
    logic [1:0]            freq;
    logic [15:0]           lo, hi, v;
    int                    fail_count, checks, seed;
    tis_top uut (.i_clk(i_clk), .i_srst(i_srst), .i_req(req), .o_rdata(rdata), .i_res(i_res),
                 .o_int_n(int_n), .o_mod_delay(delay), .o_mod_freq(freq), .o_mod_dead(dead));
    tis_host_model host (.i_clk(i_clk), .o_req(req), .i_rdata(rdata));
    // 25 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk(16'(d), 16'(e));
    endtask : rc
    // One result strobe; data inverted afterwards, #1 lets the flag edge land
    task automatic pulse(input logic p, input logic a, input logic [15:0] x);
        @(posedge i_clk);
        i_res <= '{prox_valid: p, als_valid: a, prox: x, als: x};
        @(posedge i_clk);
        i_res <= '{prox_valid: 1'b0, als_valid: 1'b0, prox: ~x, als: ~x};
        #1;
    endtask : pulse
    task automatic setlim(input logic [15:0] l, input logic [15:0] h);
        host.wr(8'h8a, l[15:8]);
        host.wr(8'h8b, l[7:0]);
        host.wr(8'h8c, h[15:8]);
        host.wr(8'h8d, h[7:0]);
    endtask : setlim
    // Expected limit flags for count code 0, ordered limits
    function automatic logic [7:0] lim_f(input logic [15:0] x, input logic [15:0] l, input logic [15:0] h);
        return {6'h00, x < l, x > h};
    endfunction : lim_f
    task automatic stop_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // Watchdog, about twenty times the expected run length
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        stop_test();
    end
    initial begin
        i_srst = 1'b1;
        i_res  = '0;
        seed   = $urandom(63);
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        // Reset values, pin idle, unmapped place ignored
        rc(8'h8f, 8'h01);
        chk(16'({delay, freq, dead}), 16'h0001);
        chk(16'(int_n), 16'h0001);
        rc(8'h8e, 8'h00);
        host.wr(8'h90, 8'hff);
        rc(8'h90, 8'h00);
        // Random limit and modulator contents read back
        repeat (4) begin
            lo = 16'($urandom);
            hi = 16'($urandom);
            m  = 8'($urandom);
            setlim(lo, hi);
            host.wr(8'h8f, m);
            for (int i = 0; i < 4; i++) rc(8'h8a + 8'(i), 8'({lo, hi} >> (24 - 8 * i)));
            rc(8'h8f, m);
            chk(16'({delay, freq, dead}), 16'(m));
        end
        host.prog_mod();
        rc(8'h8f, 8'h01);
        chk(16'({delay, freq, dead}), 16'h0001);
        // Ready events, sticky flags, clearing one bit at a time
        host.wr(8'h89, 8'h0c);
        pulse(1'b1, 1'b0, 16'h1234);
        chk(16'(int_n), 16'h0000);
        rc(8'h8e, 8'h08);
        pulse(1'b0, 1'b1, 16'h0042);
        rc(8'h8e, 8'h0c);
        host.wr(8'h8e, 8'h08);
        rc(8'h8e, 8'h04);
        host.wr(8'h8e, 8'hf4);
        rc(8'h8e, 8'h00);
        chk(16'(int_n), 16'h0001);
        host.wr(8'h89, 8'h00);
        pulse(1'b1, 1'b1, 16'h0000);
        rc(8'h8e, 8'h00);
        // Equal is not out of limit; source select; both directions
        setlim(16'h1000, 16'h2000);
        host.wr(8'h89, 8'h02);
        pulse(1'b1, 1'b0, 16'h2000);
        pulse(1'b1, 1'b0, 16'h1000);
        rc(8'h8e, 8'h00);
        pulse(1'b0, 1'b1, 16'hffff);
        rc(8'h8e, 8'h00);
        pulse(1'b1, 1'b0, 16'h2001);
        rc(8'h8e, 8'h01);
        host.wr(8'h8e, 8'h0f);
        host.wr(8'h89, 8'h03);
        pulse(1'b0, 1'b1, 16'h0fff);
        rc(8'h8e, 8'h02);
        host.wr(8'h8e, 8'h0f);
        // Persistence: an in-range sample breaks the run, then 2**code needed
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h89, {3'(c), 5'h02});
            pulse(1'b1, 1'b0, 16'h1800);
            repeat ((1 << c) - 1) pulse(1'b1, 1'b0, 16'h3000);
            rc(8'h8e, 8'h00);
            pulse(1'b1, 1'b0, 16'h3000);
            rc(8'h8e, 8'h01);
            host.wr(8'h8e, 8'h0f);
        end
        // Random ordered limits and results against the bench model
        host.wr(8'h89, 8'h02);
        repeat (12) begin
            lo = 16'($urandom);
            hi = 16'($urandom);
            v  = 16'($urandom);
            if (lo > hi) {lo, hi} = {hi, lo};
            setlim(lo, hi);
            pulse(1'b1, 1'b0, v);
            rc(8'h8e, lim_f(v, lo, hi));
            host.wr(8'h8e, 8'h0f);
        end
        // Mid-run reset with a flag set and a changed modulator byte
        host.wr(8'h8f, 8'ha5);
        host.wr(8'h89, 8'h08);
        pulse(1'b1, 1'b0, 16'h0000);
        chk(16'(int_n), 16'h0000);
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        chk(16'(int_n), 16'h0001);
        rc(8'h8e, 8'h00);
        rc(8'h8f, 8'h01);
        chk(16'({delay, freq, dead}), 16'h0001);
        rc(8'h8c, 8'h00);
        stop_test();
    end
endmodule : test_threshold_interrupt_status
`default_nettype wire
